/* File: bench/dcdc_pwm_control_test.sv */
// Self-checking bench of the dc-dc converter PWM control block.
// Assumes the switch stage model on the drive pin and a 20 MHz clock.
module dcdc_pwm_control_test
   import dcdc_pwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, peakTrip, driveOn, ffOn;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0]  tripAfter = 8'h00;
   int          miscompares = 0;
   int          cmpCount = 0;
   int          cycles = 0;
   int          rises = 0, hiRun = 0, loRun = 0, lastHi = 0, lastLo = 0;
   int          lastPer = 0;

   dcdc_pwm_control #(.FF_SAME(1'b0)) dut (
      .clk(clk), .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .peakTrip(peakTrip),
      .converter_drive_pin(driveOn), .feedforward_pin(ffOn));

   dcdc_switch_stage partner (.clk(clk), .driveOn(driveOn),
      .tripAfter(tripAfter), .peakTrip(peakTrip));

   always #25 clk = ~clk;

   task automatic stopTest;
      if (miscompares == 0 && cmpCount > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stopTest

   task automatic checkVal(input string what, input logic [31:0] exp, got);
      cmpCount++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : checkVal

   // Unknown bits make the range test unknown, which counts as a mismatch.
   task automatic checkRange(input string what, input int lo, hi,
                             input logic [31:0] got);
      cmpCount++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         miscompares++;
         $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi,
                  got);
      end
   endtask : checkRange

   // Whole clocks spanned by a number of 61.035 ns steps, rounded down.
   function automatic int clks(input int ticks);
      return ticks * 2500 / 2048;
   endfunction : clks

   // The timeout is far above the longest run of the sequence below.
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         stopTest();
      end
   end

   // Sampling at the falling edge keeps run lengths clear of edge races.
   always @(negedge clk)
   begin
      if (rst_n)
      begin
         checkVal("feedforward", {31'h0, ~driveOn}, {31'h0, ffOn});
         if (driveOn === 1'b1)
         begin
            if (loRun > 0)
            begin
               lastLo = loRun;
               lastPer = lastHi + loRun;
               rises++;
            end
            loRun = 0;
            hiRun++;
         end
         else
         begin
            if (hiRun > 0)
               lastHi = hiRun;
            hiRun = 0;
            loRun++;
         end
      end
   end

   task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] resp);
      logic aw, w, takeA, takeW;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w))
      begin
         @(negedge clk);
         takeA = !aw && s_axi_awready === 1'b1;
         takeW = !w && s_axi_wready === 1'b1;
         @(posedge clk);
         if (takeA)
            s_axi_awvalid <= 1'b0;
         if (takeW)
            s_axi_wvalid <= 1'b0;
         aw = aw || takeA;
         w = w || takeW;
      end
      do @(negedge clk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      @(posedge clk);
      s_axi_bready <= 1'b0;
   endtask : axiWrite

   task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clk); while (s_axi_arready !== 1'b1);
      @(posedge clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      s_axi_rready <= 1'b0;
   endtask : axiRead

   task automatic writeReg(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      axiWrite(a, d, 4'hf, r);
      checkVal("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask : writeReg

   task automatic expectReg(input string what, input logic [11:0] a,
                            input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axiRead(a, d, r);
      checkVal("read resp", {30'h0, RESP_OKAY}, {30'h0, r});
      checkVal(what, exp, d);
   endtask : expectReg

   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  p;
      logic [4:0]  tof;
      int          r0, t0;
      void'($urandom(73811));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      expectReg("period", ADDR_PERIOD, 32'h0000_00ff);
      expectReg("delay", ADDR_DELAY, 32'h0000_0014);
      expectReg("width", ADDR_PWIDTH, 32'h0000_0000);
      axiRead(12'h100, d, r);
      checkVal("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      checkVal("unmapped data", 32'h0000_0000, d);
      axiWrite(12'h100, 32'h0000_00ff, 4'hf, r);
      checkVal("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axiWrite(ADDR_PERIOD, 32'h0000_0080, 4'he, r);
      checkVal("strobe resp", {30'h0, RESP_OKAY}, {30'h0, r});
      expectReg("period strobe", ADDR_PERIOD, 32'h0000_00ff);
      writeReg(ADDR_DELAY, 32'h0000_0065);
      expectReg("delay fixed", ADDR_DELAY, 32'h0000_0005);
      for (int i = 0; i < 6; i++)
      begin
         // Even rounds suit field-effect switches, odd rounds bipolar ones.
         p = {i[0], 1'b0, 6'($urandom)};
         tof = 5'($urandom);
         if (i == 0)
            {p, tof} = {8'h00, 5'h1f};
         if (i == 5)
            {p, tof} = {8'hbf, 5'h00};
         writeReg(ADDR_PERIOD, {24'h00_0000, p});
         writeReg(ADDR_DELAY, {27'h0, tof});
         tripAfter <= i[0] ? 8'(8 + $urandom_range(12)) : 8'h00;
         expectReg("period rd", ADDR_PERIOD, {24'h0, p | 8'h40});
         r0 = rises;
         wait (rises >= r0 + 3);
         p = p | 8'h40;
         checkRange("period", clks(p) - 1, clks(p) + 2, lastPer);
         checkRange("off", clks(tof + 4) - 1, i[0] ? 400 : clks(tof + 4) + 2,
                    lastLo);
         axiRead(ADDR_PWIDTH, d, r);
         if (i[0])
            checkRange("width", lastHi * 2048 / 2500 + tof + 2,
                       lastHi * 2048 / 2500 + tof + 6, d);
         else
            checkVal("width", {24'h00_0000, p}, d);
      end
      tripAfter <= 8'h00;
      writeReg(ADDR_DELAY, 32'h0000_008a);
      t0 = cycles;
      // The drive is held off from here, so the next rise ends calibration.
      r0 = rises;
      expectReg("cal busy", ADDR_DELAY, 32'h0000_008a);
      do axiRead(ADDR_DELAY, d, r); while (d[CAL_BIT] === 1'b1);
      checkRange("cal time", clks(256) - 6, clks(256) + 10, cycles - t0);
      wait (rises >= r0 + 1);
      checkRange("cal off", clks(256), clks(512), lastLo);
      expectReg("cal done", ADDR_DELAY, 32'h0000_000a);
      stopTest();
   end
endmodule : dcdc_pwm_control_test

/* File: bench/dcdc_switch_stage.sv */
// Model of the external switch transistor and its peak current sense.
// Assumes the drive pin is high while the switch conducts.
module dcdc_switch_stage
(
   input  wire logic       clk,
   input  wire logic       driveOn,
   input  wire logic [7:0] tripAfter,
   output logic            peakTrip
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] onClks;
   initial onClks = 8'h00;
   initial peakTrip = 1'b0;
   // Current ramps while the switch is on; a zero limit never trips.
   always @(posedge clk)
   begin
      onClks <= driveOn ? onClks + 8'h01 : 8'h00;
      peakTrip <= driveOn && tripAfter != 8'h00 && onClks >= tripAfter;
   end
endmodule : dcdc_switch_stage

/* File: verilog/dcdc_pwm_control.sv */
// Dc-dc converter PWM control with AXI4-Lite register access.
// Assumes peakTrip is asynchronous and the bus runs on clk.
// Behaviour
// - Period equals period code in 61.035 ns steps.
// - Period bit six reads one, ignores writes.
// - Writing calibration bit one starts calibration.
// - Calibration bit reads one while calibrating.
// - Read-only bit five shows feed-forward polarity.
// - Polarity zero inverted, one same, fixed variant.
// - Minimum off time is (code plus four) steps.
// - Width readback equals on steps plus code plus four.
module dcdc_pwm_control
   import dcdc_pwm_pkg::*;
#(
   parameter logic FF_SAME = 1'b0
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        peakTrip,
   output logic             converter_drive_pin,
   output logic             feedforward_pin
);

   logic        tick;
   logic        tripMeta;
   logic        tripSync;
   cfg_t        cfg;
   cfg_t        next_cfg;
   pwm_t        pwm;
   pwm_t        next_pwm;
   logic        awHeld;
   logic        wHeld;
   logic [11:0] awAddr;
   logic [7:0]  wByte;
   logic        wLane;
   logic        next_awHeld;
   logic        next_wHeld;
   logic [11:0] next_awAddr;
   logic [7:0]  next_wByte;
   logic        next_wLane;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_rvalid;
   logic [1:0]  next_rresp;
   logic [31:0] next_rdata;
   logic        next_awready;
   logic        next_wready;
   logic        next_arready;
   logic        next_drive;
   logic        next_ff;
   logic        calWrite;
   logic        calBusy;
   logic [7:0]  offStart;

   dcdc_tick_gen u_tick (
      .clk   (clk),
      .rst_n (rst_n),
      .tick  (tick)
   );

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tripMeta <= 1'b0;
         tripSync <= 1'b0;
      end
      else
      begin
         tripMeta <= peakTrip;
         tripSync <= tripMeta;
      end
   end

   assign calBusy  = (pwm.phase == PH_CAL);
   assign offStart = cfg.periodCode - ({3'h0, cfg.offTimeCode} + TOF_OFFSET);

   // Register bus: address and data may arrive in either order.
   always_comb
   begin
      next_awHeld = awHeld;
      next_wHeld  = wHeld;
      next_awAddr = awAddr;
      next_wByte  = wByte;
      next_wLane  = wLane;
      next_bvalid = s_axi_bvalid;
      next_bresp  = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rresp  = s_axi_rresp;
      next_rdata  = s_axi_rdata;
      next_cfg    = cfg;
      calWrite    = 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_awHeld = 1'b1;
         next_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_wHeld = 1'b1;
         next_wByte = s_axi_wdata[7:0];
         next_wLane = s_axi_wstrb[0];
      end
      if (awHeld && wHeld && !s_axi_bvalid)
      begin
         next_awHeld = 1'b0;
         next_wHeld  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = RESP_OKAY;
         unique case (awAddr)
            ADDR_PERIOD:
            begin
               if (wLane)
                  next_cfg.periodCode = wByte | 8'h40;
            end
            ADDR_DELAY:
            begin
               if (wLane)
               begin
                  next_cfg.offTimeCode = wByte[4:0];
                  calWrite = wByte[CAL_BIT];
               end
            end
            ADDR_PWIDTH: ;
            default: next_bresp = RESP_SLVERR;
         endcase
      end
      if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         unique case (s_axi_araddr)
            ADDR_PERIOD: next_rdata[7:0] = cfg.periodCode;
            ADDR_DELAY:
            begin
               next_rdata[CAL_BIT]  = calBusy;
               next_rdata[POL_BIT]  = FF_SAME;
               next_rdata[4:0]      = cfg.offTimeCode;
            end
            ADDR_PWIDTH: next_rdata[7:0] = pwm.widthCode;
            default: next_rresp = RESP_SLVERR;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         next_rvalid = 1'b0;
      next_awready = !next_awHeld && !next_bvalid;
      next_wready  = !next_wHeld && !next_bvalid;
      next_arready = !next_rvalid;
   end

   // PWM sequencer; the off phase always spans at least the minimum off
   // time because the period code is never below 64 steps.
   always_comb
   begin
      next_pwm = pwm;
      if (calWrite)
      begin
         next_pwm.phase  = PH_CAL;
         next_pwm.calCnt = CAL_TICKS - 9'h001;
         next_pwm.cnt    = 8'h00;
         next_pwm.onCnt  = 8'h00;
      end
      else if (tick)
      begin
         unique case (pwm.phase)
            PH_CAL:
            begin
               if (pwm.calCnt == 9'h000)
                  next_pwm.phase = PH_ON;
               else
                  next_pwm.calCnt = pwm.calCnt - 9'h001;
            end
            PH_ON, PH_OFF:
            begin
               if (pwm.cnt >= cfg.periodCode - 8'h01)
               begin
                  next_pwm.cnt       = 8'h00;
                  next_pwm.onCnt     = 8'h00;
                  next_pwm.phase     = PH_ON;
                  next_pwm.widthCode = pwm.onCnt
                     + {3'h0, cfg.offTimeCode} + TOF_OFFSET;
               end
               else
               begin
                  next_pwm.cnt = pwm.cnt + 8'h01;
                  if (pwm.phase == PH_ON)
                  begin
                     next_pwm.onCnt = pwm.onCnt + 8'h01;
                     if (tripSync || pwm.cnt + 8'h01 >= offStart)
                        next_pwm.phase = PH_OFF;
                  end
               end
            end
            default: next_pwm.phase = PH_OFF;
         endcase
      end
      next_drive = (next_pwm.phase == PH_ON);
      next_ff    = FF_SAME ? next_drive : !next_drive;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg                 <= '{periodCode: RST_PERIOD,
                                  offTimeCode: RST_TOF};
         pwm                 <= '{phase: PH_ON, cnt: 8'h00, onCnt: 8'h00,
                                  calCnt: 9'h000, widthCode: RST_PWIDTH};
         awHeld              <= 1'b0;
         wHeld               <= 1'b0;
         awAddr              <= 12'h000;
         wByte               <= 8'h00;
         wLane               <= 1'b0;
         s_axi_awready       <= 1'b0;
         s_axi_wready        <= 1'b0;
         s_axi_bvalid        <= 1'b0;
         s_axi_bresp         <= RESP_OKAY;
         s_axi_arready       <= 1'b0;
         s_axi_rvalid        <= 1'b0;
         s_axi_rresp         <= RESP_OKAY;
         s_axi_rdata         <= 32'h0000_0000;
         converter_drive_pin <= 1'b0;
         feedforward_pin     <= !FF_SAME;
      end
      else
      begin
         cfg                 <= next_cfg;
         pwm                 <= next_pwm;
         awHeld              <= next_awHeld;
         wHeld               <= next_wHeld;
         awAddr              <= next_awAddr;
         wByte               <= next_wByte;
         wLane               <= next_wLane;
         s_axi_awready       <= next_awready;
         s_axi_wready        <= next_wready;
         s_axi_bvalid        <= next_bvalid;
         s_axi_bresp         <= next_bresp;
         s_axi_arready       <= next_arready;
         s_axi_rvalid        <= next_rvalid;
         s_axi_rresp         <= next_rresp;
         s_axi_rdata         <= next_rdata;
         converter_drive_pin <= next_drive;
         feedforward_pin     <= next_ff;
      end
   end

   // A new setting needs up to two clocks, one step tick, to take hold.
   a_period_bit6: assert property (@(posedge clk)
      disable iff (!rst_n) cfg.periodCode[PERIOD_FIXED_BIT])
      else $error("period bit six is not one");
   a_period_wrap: assert property (@(posedge clk)
      disable iff (!rst_n) $past(cfg) == cfg && $past(cfg, 2) == cfg
      |-> pwm.cnt < cfg.periodCode)
      else $error("period counter past period code");
   a_cal_start: assert property (@(posedge clk) disable iff (!rst_n)
      calWrite |=> calBusy && pwm.calCnt == CAL_TICKS - 9'h001)
      else $error("calibration did not start");
   a_cal_read: assert property (@(posedge clk) disable iff (!rst_n)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_DELAY
      |=> s_axi_rdata[CAL_BIT] == $past(calBusy))
      else $error("calibration bit reads wrong");
   a_pol_read: assert property (@(posedge clk) disable iff (!rst_n)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_DELAY
      |=> s_axi_rdata[POL_BIT] == FF_SAME && !s_axi_rdata[6])
      else $error("polarity bit reads wrong");
   a_ff_follow: assert property (@(posedge clk) disable iff (!rst_n)
      feedforward_pin == (FF_SAME ? converter_drive_pin
                                  : !converter_drive_pin))
      else $error("feed-forward pin polarity wrong");
   a_off_time: assert property (@(posedge clk) disable iff (!rst_n)
      pwm.phase == PH_ON && $past(cfg) == cfg && $past(cfg, 2) == cfg
      |-> pwm.cnt < offStart)
      else $error("drive on inside minimum off time");
   a_width_code: assert property (@(posedge clk) disable iff (!rst_n)
      tick && !calWrite && !calBusy && pwm.cnt >= cfg.periodCode - 8'h01
      |=> pwm.widthCode == $past(pwm.onCnt) + {3'h0, $past(cfg.offTimeCode)}
          + TOF_OFFSET)
      else $error("pulse width code wrong");
   a_tick_only: assert property (@(posedge clk) disable iff (!rst_n)
      !tick && !calWrite |=> $stable(pwm.cnt) && $stable(pwm.phase))
      else $error("counter moved without tick");
   a_cal_drive: assert property (@(posedge clk) disable iff (!rst_n)
      calBusy |-> !converter_drive_pin)
      else $error("drive active during calibration");

endmodule : dcdc_pwm_control

/* File: verilog/dcdc_pwm_pkg.sv */
// Constants, register map and types of the dc-dc converter PWM control.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package dcdc_pwm_pkg;

   localparam int CLK_HZ        = 20_000_000;
   localparam int CLK_PERIOD_NS = 50;
   // One PWM step is 61.035 ns, that is one tick of a 16.384 MHz rate.
   localparam int STEP_PS       = 61_035;
   localparam int TICK_HZ       = 16_384_000;
   // Fractional accumulator: add TICK_HZ/1000 each clock, wrap at CLK_HZ/1000.
   localparam int ACC_STEP      = TICK_HZ / 1000;
   localparam int ACC_WRAP      = CLK_HZ / 1000;
   localparam int ACC_W         = 15;

   // Printed register indices; byte address is four times the index.
   localparam logic [7:0]  IDX_PERIOD  = 8'h5c;
   localparam logic [7:0]  IDX_DELAY   = 8'h5d;
   localparam logic [7:0]  IDX_PWIDTH  = 8'h5e;
   localparam logic [11:0] ADDR_PERIOD = {2'h0, IDX_PERIOD, 2'h0};
   localparam logic [11:0] ADDR_DELAY  = {2'h0, IDX_DELAY, 2'h0};
   localparam logic [11:0] ADDR_PWIDTH = {2'h0, IDX_PWIDTH, 2'h0};

   localparam logic [7:0] RST_PERIOD = 8'hff;
   localparam logic [4:0] RST_TOF    = 5'h14;
   localparam logic [7:0] RST_PWIDTH = 8'h00;

   localparam int PERIOD_FIXED_BIT = 6;
   localparam int CAL_BIT          = 7;
   localparam int POL_BIT          = 5;
   localparam logic [7:0] TOF_OFFSET = 8'h04;
   localparam logic [8:0] CAL_TICKS  = 9'h100;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      PH_ON  = 3'b001,
      PH_OFF = 3'b010,
      PH_CAL = 3'b100
   } phase_t;

   typedef struct packed {
      logic [7:0] periodCode;
      logic [4:0] offTimeCode;
   } cfg_t;

   typedef struct packed {
      phase_t     phase;
      logic [7:0] cnt;
      logic [7:0] onCnt;
      logic [8:0] calCnt;
      logic [7:0] widthCode;
   } pwm_t;

endpackage : dcdc_pwm_pkg

/* File: verilog/dcdc_tick_gen.sv */
// Step tick generator: one-cycle pulses at the PWM step rate.
// Assumes the system clock rate given in the package.
module dcdc_tick_gen
   import dcdc_pwm_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   output logic      tick
);

   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] next_acc;
   logic             next_tick;
   logic [ACC_W:0]   sum;

   // Spacing of ticks jitters by one clock; the mean rate is exact.
   always_comb
   begin
      sum = {1'b0, acc} + (ACC_W+1)'(ACC_STEP);
      if (sum >= (ACC_W+1)'(ACC_WRAP))
      begin
         next_acc  = ACC_W'(sum - (ACC_W+1)'(ACC_WRAP));
         next_tick = 1'b1;
      end
      else
      begin
         next_acc  = sum[ACC_W-1:0];
         next_tick = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc  <= '0;
         tick <= 1'b0;
      end
      else
      begin
         acc  <= next_acc;
         tick <= next_tick;
      end
   end

endmodule : dcdc_tick_gen
